// ===== qdac_code_split.sv
`timescale 1ns/1ps
// Splits one straight binary code into segment switches and ladder switches.
module qdac_code_split (
    input  wire logic                           clk,
    input  wire logic                           rst,
    input  wire logic [qdac_pkg::CODE_W-1:0]    code,
    output logic      [qdac_pkg::SEG_W-1:0]     segSwitch,
    output logic      [qdac_pkg::LADDER_W-1:0]  ladderSwitch
);
    function automatic logic [qdac_pkg::SEG_W-1:0] thermo(input logic [3:0] v);
        logic [qdac_pkg::SEG_W-1:0] t;
        t = '0;
        for (int i = 0; i < qdac_pkg::SEG_W; i++) begin
            t[i] = (v > 4'(i));
        end
        return t;
    endfunction

    wire logic [3:0] upper = code[qdac_pkg::CODE_W-1:qdac_pkg::LADDER_W];

    always_ff @(posedge clk) begin
        if (rst) begin
            segSwitch    <= '0;
            ladderSwitch <= '0;
        end else begin
            segSwitch    <= thermo(upper);
            ladderSwitch <= code[qdac_pkg::LADDER_W-1:0];
        end
    end
endmodule

// ===== qdac_core.sv
// Added by the designer: the placing of the registers and register access over APB.
`timescale 1ns/1ps
module qdac_core #(
    parameter int CalWaitCycles = qdac_pkg::CAL_CYCLES
) (
    input  wire logic                                   clk,
    input  wire logic                                   rst,
    input  wire logic [qdac_pkg::ADDR_W-1:0]            paddr,
    input  wire logic                                   psel,
    input  wire logic                                   penable,
    input  wire logic                                   pwrite,
    input  wire logic [31:0]                            pwdata,
    output logic      [31:0]                            prdata,
    output logic                                        pready,
    output logic                                        pslverr,
    input  wire logic                                   sclk,
    input  wire logic                                   syncN,
    input  wire logic                                   sdin,
    input  wire logic                                   loadStrobeN,
    input  wire logic                                   powerOnOutputSelect,
    output logic      [qdac_pkg::NUM_CH*qdac_pkg::SEG_W-1:0]    segSwitch,
    output logic      [qdac_pkg::NUM_CH*qdac_pkg::LADDER_W-1:0] ladderSwitch,
    output logic      [qdac_pkg::NUM_CH-1:0]            voutEn,
    output logic      [qdac_pkg::NUM_CH-1:0]            ioutEn,
    output logic      [qdac_pkg::NUM_CH-1:0]            voutPulldown,
    output logic      [qdac_pkg::NUM_CH*qdac_pkg::RANGE_W-1:0]  rangeSel,
    output logic      [qdac_pkg::NUM_CH-1:0]            rangeBipolar
);
    localparam int NCH = qdac_pkg::NUM_CH;
    localparam logic [15:0] CAL_LOAD = 16'(CalWaitCycles);

    // Pin synchronisers: stage a is read only by stage b.
    logic [3:0] pinA_q, pinB_q, pinC_q;
    logic       pocA_q, pocB_q;
    always_ff @(posedge clk) begin
        if (rst) begin
            // Idle levels: frame select and serial clock high, so no false edge follows reset.
            pinA_q <= 4'h6;
            pinB_q <= 4'h6;
            pinC_q <= 4'h6;
            pocA_q <= 1'b0;
            pocB_q <= 1'b0;
        end else begin
            pinA_q <= {loadStrobeN, syncN, sclk, sdin};
            pinB_q <= pinA_q;
            pinC_q <= pinB_q;
            pocA_q <= powerOnOutputSelect;
            pocB_q <= pocA_q;
        end
    end

    wire logic sdinS    = pinB_q[0];
    wire logic sclkFall = pinC_q[1] & ~pinB_q[1];
    wire logic syncLow  = ~pinB_q[2];
    wire logic syncFall = pinC_q[2] & ~pinB_q[2];
    wire logic syncRise = ~pinC_q[2] & pinB_q[2];
    wire logic ldLow    = ~pinB_q[3];
    wire logic ldFall   = pinC_q[3] & ~pinB_q[3];

    // Registers.
    logic                   pec_q;
    logic                   frameErr_q;
    logic [NCH-1:0][4:0]    chCtl_q;
    logic [NCH-1:0][15:0]   clearCode_q, dataReg_q, pend_q, outCode_q;
    logic [NCH-1:0]         taken_q;
    logic [31:0]            shift_q;
    logic [5:0]             bitCnt_q;
    logic [15:0]            calCnt_q;
    logic [1:0]             strapCnt_q;
    logic                   pocVal_q;

    // Serial shift path.
    always_ff @(posedge clk) begin
        if (rst) begin
            shift_q  <= '0;
            bitCnt_q <= '0;
        end else if (syncFall) begin
            bitCnt_q <= '0;
        end else if (syncLow && sclkFall) begin
            shift_q  <= {shift_q[30:0], sdinS};
            if (bitCnt_q != 6'h3f) begin
                bitCnt_q <= bitCnt_q + 6'h01;
            end
        end
    end

    // Frame decode at the frame select rising edge.
    wire logic [5:0]  expBits = pec_q ? 6'(qdac_pkg::SHIFT_W) : 6'(qdac_pkg::FRAME_BITS);
    wire logic [23:0] word    = pec_q ? shift_q[31:8] : shift_q[23:0];
    wire logic        lenOk   = (bitCnt_q == expBits);
    wire logic        frameEnd = syncRise & lenOk;
    wire logic        frameBad = syncRise & ~lenOk & (bitCnt_q != 6'h00);
    wire logic        dataWr  = frameEnd & ~word[qdac_pkg::FRM_READ_BIT]
                              & (word[qdac_pkg::FRM_SEL_HI:qdac_pkg::FRM_SEL_LO]
                                 == qdac_pkg::FRM_SEL_DATA);
    wire logic [1:0]  wrCh    = word[qdac_pkg::FRM_CH_HI:qdac_pkg::FRM_CH_LO];
    wire logic [15:0] wrCode  = word[15:0];

    // APB slave: one wait state so read data comes from a flop.
    wire logic        apbAcc  = psel & penable & pready;
    wire logic [3:0]  page    = paddr[7:4];
    wire logic [1:0]  regCh   = paddr[3:2];
    wire logic        isMain  = (paddr == qdac_pkg::ADDR_MAIN);
    wire logic        isStat  = (paddr == qdac_pkg::ADDR_STATUS);
    wire logic        isCtl   = (page == qdac_pkg::PAGE_CTRL);
    wire logic        isClr   = (page == qdac_pkg::PAGE_CLEAR);
    wire logic        isData  = (page == qdac_pkg::PAGE_DATA);
    wire logic        isOut   = (page == qdac_pkg::PAGE_OUT);
    wire logic        mapped  = (isMain | isStat | isCtl | isClr | isData | isOut)
                              & (paddr[1:0] == 2'h0);
    wire logic        wrMain  = apbAcc & pwrite & isMain;
    wire logic        wrStat  = apbAcc & pwrite & isStat;
    wire logic        wrCtl   = apbAcc & pwrite & isCtl & mapped;
    wire logic        wrClr   = apbAcc & pwrite & isClr & mapped;
    wire logic        clrCmd  = wrMain & pwdata[qdac_pkg::MAIN_CLEAR];
    wire logic        calBusy = (calCnt_q != 16'h0000);

    logic [31:0] rdMux;
    always_comb begin
        rdMux = '0;
        if (isMain) begin
            rdMux[qdac_pkg::MAIN_PEC] = pec_q;
        end else if (isStat) begin
            rdMux[qdac_pkg::ST_BUSY]     = calBusy;
            rdMux[qdac_pkg::ST_FRAMEERR] = frameErr_q;
            rdMux[qdac_pkg::ST_POC]      = pocVal_q;
            rdMux[qdac_pkg::ST_TAKEN_LO +: NCH] = taken_q;
        end else if (isCtl) begin
            rdMux[qdac_pkg::CTL_W-1:0] = chCtl_q[regCh];
        end else if (isClr) begin
            rdMux[15:0] = clearCode_q[regCh];
        end else if (isData) begin
            rdMux[15:0] = dataReg_q[regCh];
        end else if (isOut) begin
            rdMux[15:0] = outCode_q[regCh];
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            pready  <= 1'b0;
            prdata  <= '0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel & penable & ~pready;
            prdata  <= mapped ? rdMux : 32'h0000_0000;
            pslverr <= psel & penable & ~pready & ~mapped;
        end
    end

    // Software registers; reset values give range 0-5 V and zero clear codes.
    always_ff @(posedge clk) begin
        if (rst) begin
            pec_q       <= 1'b0;
            frameErr_q  <= 1'b0;
            chCtl_q     <= '{default: 5'h00};
            clearCode_q <= '{default: qdac_pkg::CLEAR_CODE_RST};
        end else begin
            if (wrMain) begin
                pec_q <= pwdata[qdac_pkg::MAIN_PEC];
            end
            // A bad frame in the clearing cycle keeps the flag set.
            if (frameBad) begin
                frameErr_q <= 1'b1;
            end else if (wrStat && pwdata[qdac_pkg::ST_FRAMEERR]) begin
                frameErr_q <= 1'b0;
            end
            if (wrCtl) begin
                chCtl_q[regCh] <= pwdata[qdac_pkg::CTL_W-1:0];
            end
            if (wrClr) begin
                clearCode_q[regCh] <= pwdata[15:0];
            end
        end
    end

    // Data, pending and output codes.
    always_ff @(posedge clk) begin
        if (rst) begin
            dataReg_q <= '{default: qdac_pkg::CODE_RST};
            pend_q    <= '{default: qdac_pkg::CODE_RST};
            outCode_q <= '{default: qdac_pkg::CODE_RST};
            taken_q   <= '0;
        end else begin
            if (ldFall) begin
                taken_q <= '0;
            end
            for (int c = 0; c < NCH; c++) begin
                if (ldFall && !dataWr) begin
                    outCode_q[c] <= pend_q[c];
                end
                if (clrCmd && chCtl_q[c][qdac_pkg::CTL_CLR_EN]) begin
                    outCode_q[c] <= clearCode_q[c];
                    pend_q[c]    <= clearCode_q[c];
                end
            end
            if (dataWr) begin
                dataReg_q[wrCh] <= wrCode;
                if (ldLow) begin
                    outCode_q[wrCh] <= wrCode;
                    pend_q[wrCh]    <= wrCode;
                end else if (!taken_q[wrCh]) begin
                    pend_q[wrCh]  <= wrCode;
                    taken_q[wrCh] <= 1'b1;
                end
            end
        end
    end

    // Calibration timer and strap capture after reset release.
    always_ff @(posedge clk) begin
        if (rst) begin
            calCnt_q   <= CAL_LOAD;
            strapCnt_q <= 2'(qdac_pkg::STRAP_SETTLE);
            pocVal_q   <= 1'b0;
        end else begin
            if (calBusy) begin
                calCnt_q <= calCnt_q - 16'h0001;
            end
            if (strapCnt_q != 2'h0) begin
                strapCnt_q <= strapCnt_q - 2'h1;
                pocVal_q   <= pocB_q;
            end
        end
    end

    // Output configuration; bipolar ranges are offset binary, 0x8000 at zero.
    always_ff @(posedge clk) begin
        if (rst) begin
            voutEn       <= '0;
            ioutEn       <= '0;
            voutPulldown <= '0;
            rangeSel     <= '0;
            rangeBipolar <= '0;
        end else begin
            for (int c = 0; c < NCH; c++) begin
                automatic logic [2:0] r = chCtl_q[c][2:0];
                automatic logic en = chCtl_q[c][qdac_pkg::CTL_OUT_EN];
                automatic logic isI = (r == qdac_pkg::RNG_4_20MA) | (r == qdac_pkg::RNG_0_20MA)
                                    | (r == qdac_pkg::RNG_0_24MA);
                automatic logic isV = (r <= qdac_pkg::RNG_PM10V);
                voutEn[c]       <= en & isV;
                ioutEn[c]       <= en & isI;
                voutPulldown[c] <= ~(en & isV) & pocVal_q;
                rangeSel[c*3 +: 3] <= r;
                rangeBipolar[c] <= (r == qdac_pkg::RNG_PM5V) | (r == qdac_pkg::RNG_PM10V);
            end
        end
    end

    for (genvar g = 0; g < NCH; g++) begin : gSplit
        qdac_code_split uSplit (
            .clk          (clk),
            .rst          (rst),
            .code         (outCode_q[g]),
            .segSwitch    (segSwitch[g*qdac_pkg::SEG_W +: qdac_pkg::SEG_W]),
            .ladderSwitch (ladderSwitch[g*qdac_pkg::LADDER_W +: qdac_pkg::LADDER_W])
        );
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    property p_one_output;
        (voutEn & ioutEn) == '0;
    endproperty
    a_one_output: assert property (p_one_output) else $error("both outputs enabled");

    property p_indiv_update;
        logic [1:0] ch;
        logic [15:0] v;
        (dataWr && ldLow && !clrCmd, ch = wrCh, v = wrCode) |=> outCode_q[ch] == v;
    endproperty
    a_indiv_update: assert property (p_indiv_update) else $error("individual update missed");

    property p_first_only;
        (dataWr && !ldLow && taken_q[wrCh] && !clrCmd) |=> $stable(pend_q);
    endproperty
    a_first_only: assert property (p_first_only) else $error("later write reached pending");

    property p_simul;
        (ldFall && !dataWr && !clrCmd) |=> outCode_q == $past(pend_q);
    endproperty
    a_simul: assert property (p_simul) else $error("simultaneous update wrong");

    property p_taken_clear;
        ldFall |=> taken_q == '0;
    endproperty
    a_taken_clear: assert property (p_taken_clear) else $error("taken flags not cleared");

    property p_bad_len;
        (syncRise && !lenOk) |=> $stable(dataReg_q);
    endproperty
    a_bad_len: assert property (p_bad_len) else $error("wrong length frame stored");

    property p_pec_len;
        (syncRise && pec_q && bitCnt_q == 6'd32 && dataWr) |=> dataReg_q[$past(wrCh)] == $past(wrCode);
    endproperty
    a_pec_len: assert property (p_pec_len) else $error("32-bit frame not taken");

    property p_no_shift_idle;
        !syncLow |=> $stable(shift_q);
    endproperty
    a_no_shift_idle: assert property (p_no_shift_idle) else $error("shift while frame idle");

    property p_pulldown;
        (strapCnt_q == 2'h0 && !voutEn[0]) ##1 (strapCnt_q == 2'h0 && !voutEn[0])
            |-> voutPulldown[0] == pocVal_q;
    endproperty
    a_pulldown: assert property (p_pulldown) else $error("pull-down does not follow strap");

    property p_clear;
        (clrCmd && chCtl_q[0][qdac_pkg::CTL_CLR_EN] && !dataWr) |=> outCode_q[0] == $past(clearCode_q[0]);
    endproperty
    a_clear: assert property (p_clear) else $error("clear code not applied");

    property p_range_reset;
        $fell(rst) |-> chCtl_q[0][2:0] == qdac_pkg::RNG_0_5V;
    endproperty
    a_range_reset: assert property (@(posedge clk) p_range_reset) else $error("range not 0-5 V");

    c_indiv: cover property (dataWr && ldLow);
    c_simul: cover property (ldFall && taken_q != '0);
    c_pec:   cover property (frameEnd && pec_q);
    c_bad:   cover property (frameBad);
endmodule

// ===== qdac_core_test.sv
`timescale 1ns/1ps
module qdac_core_test;
    typedef struct packed {
        logic [1:0]  ch;
        logic [15:0] code;
    } qdac_row_t;

    logic        clk, rst, psel, penable, pwrite, pready, pslverr, loadStrobeN, strap, err;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    wire         sclk, syncN, sdin;
    logic [59:0] segSwitch;
    logic [47:0] ladderSwitch;
    logic [11:0] rangeSel;
    logic [3:0]  voutEn, ioutEn, voutPulldown, rangeBipolar;
    int          mismatches, total_checks;
    qdac_row_t   rows [5] = '{'{2'd0, 16'h0000}, '{2'd1, 16'hffff}, '{2'd2, 16'h8000},
                              '{2'd3, 16'h7fff}, '{2'd0, 16'h1234}};

    qdac_core #(.CalWaitCycles(20)) dut (
        .clk(clk), .rst(rst), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .sclk(sclk), .syncN(syncN), .sdin(sdin),
        .loadStrobeN(loadStrobeN), .powerOnOutputSelect(strap), .segSwitch(segSwitch),
        .ladderSwitch(ladderSwitch), .voutEn(voutEn), .ioutEn(ioutEn),
        .voutPulldown(voutPulldown), .rangeSel(rangeSel), .rangeBipolar(rangeBipolar));
    qdac_serial_host host (.sclk(sclk), .syncN(syncN), .sdin(sdin));

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic fail(input string msg);
        mismatches++;
        $display("[ERR] %0t %s", $time, msg);
    endtask

    task automatic checkWord(input logic [31:0] got, input logic [31:0] exp, input string msg);
        total_checks++;
        if (got !== exp) begin
            fail(msg);
        end
    endtask

    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        paddr   <= a;
        pwrite  <= w;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            fail("apb answer missing");
            report_and_stop();
        end
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    function automatic logic [14:0] therm(input logic [15:0] code);
        logic [15:0] t;
        t = (16'h0001 << code[15:12]) - 16'h0001;
        return t[14:0];
    endfunction

    task automatic frame(input logic [1:0] ch, input logic [15:0] code);
        host.send({8'h00, 6'h00, ch, code}, 24);
    endtask

    // Waits for the channel's switches to show the code, then checks them and the readback.
    task automatic waitOut(input logic [1:0] ch, input logic [15:0] code);
        int n;
        n = 0;
        while (n < 60 && (ladderSwitch[ch*12+:12] !== code[11:0]
               || segSwitch[ch*15+:15] !== therm(code))) begin
            @(negedge clk);
            n++;
        end
        checkWord(32'(segSwitch[ch*15+:15]), 32'(therm(code)), "segment switches");
        checkWord(32'(ladderSwitch[ch*12+:12]), 32'(code[11:0]), "ladder switches");
        apb(8'h40 + 8'(ch) * 8'h04, 1'b0, 32'h0);
        checkWord(rd, 32'(code), "output code");
    endtask

    task automatic doReset(input logic s);
        int n;
        @(posedge clk);
        rst   <= 1'b1;
        strap <= s;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        repeat (10) @(posedge clk);
        checkWord(32'(voutPulldown), s ? 32'hf : 32'h0, "pull-down");
        checkWord(32'(voutEn | ioutEn), 32'h0, "outputs enabled");
        checkWord(32'(rangeSel), 32'h0, "range pins");
        apb(qdac_pkg::ADDR_STATUS, 1'b0, 32'h0);
        checkWord(32'(rd[0]), 32'h1, "busy after reset");
        n = 0;
        while (rd[0] !== 1'b0 && n < 100) begin
            apb(qdac_pkg::ADDR_STATUS, 1'b0, 32'h0);
            n++;
        end
        checkWord(32'(rd[0]), 32'h0, "busy stuck");
        for (int c = 0; c < 4; c++) begin
            apb(8'h10 + 8'(c) * 8'h04, 1'b0, 32'h0);
            checkWord(rd, 32'h0, "control reset");
            apb(8'h20 + 8'(c) * 8'h04, 1'b0, 32'h0);
            checkWord(rd, 32'h0, "clear code reset");
        end
    endtask

    initial begin
        rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        loadStrobeN = 1'b0;
        strap = 1'b1;
        doReset(1'b1);
        apb(8'h80, 1'b0, 32'h0);
        checkWord({rd[30:0], err}, 32'h1, "unmapped read");
        apb(8'h11, 1'b1, 32'h7);
        checkWord(32'(err), 32'h1, "unaligned write");
        foreach (rows[i]) begin
            frame(rows[i].ch, rows[i].code);
            waitOut(rows[i].ch, rows[i].code);
        end
        for (int r = 0; r < 8; r++) begin
            apb(8'h10, 1'b1, 32'h8 | 32'(r));
            repeat (3) @(posedge clk);
            checkWord(32'(rangeSel[2:0]), 32'(r), "range select");
            checkWord(32'(voutEn[0]), 32'(r < 4), "voltage enable");
            checkWord(32'(ioutEn[0]), 32'(r >= 4 && r < 7), "current enable");
            checkWord(32'(rangeBipolar[0]), 32'(r == 2 || r == 3), "bipolar");
        end
        apb(8'h14, 1'b1, 32'h18);
        frame(2'd1, 16'hffff);
        waitOut(2'd1, 16'hffff);
        apb(qdac_pkg::ADDR_MAIN, 1'b1, 32'h2);
        waitOut(2'd1, 16'h0000);
        apb(qdac_pkg::ADDR_MAIN, 1'b1, 32'h1);
        host.send({6'h00, 2'd3, 16'h4321, 8'ha5}, 32);
        waitOut(2'd3, 16'h4321);
        host.send({8'h00, 6'h00, 2'd3, 16'h0055}, 24);
        repeat (10) @(posedge clk);
        apb(qdac_pkg::ADDR_STATUS, 1'b0, 32'h0);
        checkWord(32'(rd[1]), 32'h1, "short frame flagged");
        waitOut(2'd3, 16'h4321);
        apb(qdac_pkg::ADDR_STATUS, 1'b1, 32'h2);
        apb(qdac_pkg::ADDR_STATUS, 1'b0, 32'h0);
        checkWord(32'(rd[1]), 32'h0, "error flag clear");
        apb(qdac_pkg::ADDR_MAIN, 1'b1, 32'h0);
        frame(2'd2, 16'h0f0f);
        waitOut(2'd2, 16'h0f0f);
        @(posedge clk);
        loadStrobeN <= 1'b1;
        frame(2'd2, 16'h1111);
        frame(2'd2, 16'h2222);
        frame(2'd3, 16'h3333);
        repeat (10) @(posedge clk);
        apb(8'h48, 1'b0, 32'h0);
        checkWord(rd, 32'h0f0f, "held output");
        apb(8'h38, 1'b0, 32'h0);
        checkWord(rd, 32'h2222, "data register");
        apb(qdac_pkg::ADDR_STATUS, 1'b0, 32'h0);
        checkWord(32'(rd[7:4]), 32'hc, "taken flags");
        @(posedge clk);
        loadStrobeN <= 1'b0;
        waitOut(2'd2, 16'h1111);
        waitOut(2'd3, 16'h3333);
        apb(qdac_pkg::ADDR_STATUS, 1'b0, 32'h0);
        checkWord(32'(rd[7:4]), 32'h0, "taken flags cleared");
        doReset(1'b0);
        report_and_stop();
    end
endmodule

// ===== qdac_pkg.sv
package qdac_pkg;

    localparam int NUM_CH     = 4;
    localparam int CODE_W     = 16;
    localparam int SEG_W      = 15;
    localparam int LADDER_W   = 12;
    localparam int RANGE_W    = 3;
    localparam int FRAME_BITS = 24;
    localparam int PEC_BITS   = 8;
    localparam int SHIFT_W    = FRAME_BITS + PEC_BITS;
    localparam int CNT_W      = 6;

    // Timing: calibration wait after reset.
    localparam int CLK_MHZ      = 200;
    localparam int CAL_WAIT_US  = 100;
    localparam int CAL_CYCLES   = CAL_WAIT_US * CLK_MHZ;
    localparam int STRAP_SETTLE = 3;

    // Frame field layout (24-bit word, bit 23 first on the wire).
    localparam int FRM_READ_BIT = 23;
    localparam int FRM_SEL_HI   = 20;
    localparam int FRM_SEL_LO   = 18;
    localparam int FRM_CH_HI    = 17;
    localparam int FRM_CH_LO    = 16;
    localparam logic [2:0] FRM_SEL_DATA = 3'h0;

    // APB map, byte addresses.
    localparam int ADDR_W = 8;
    localparam logic [7:0] ADDR_MAIN   = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [3:0] PAGE_CTRL   = 4'h1;
    localparam logic [3:0] PAGE_CLEAR  = 4'h2;
    localparam logic [3:0] PAGE_DATA   = 4'h3;
    localparam logic [3:0] PAGE_OUT    = 4'h4;

    // Main register bits.
    localparam int MAIN_PEC   = 0;
    localparam int MAIN_CLEAR = 1;
    // Status register bits.
    localparam int ST_BUSY     = 0;
    localparam int ST_FRAMEERR = 1;
    localparam int ST_POC      = 2;
    localparam int ST_TAKEN_LO = 4;
    // Channel control bits.
    localparam int CTL_RANGE_LO = 0;
    localparam int CTL_OUT_EN   = 3;
    localparam int CTL_CLR_EN   = 4;
    localparam int CTL_W        = 5;

    // Output ranges.
    localparam logic [2:0] RNG_0_5V   = 3'h0;
    localparam logic [2:0] RNG_0_10V  = 3'h1;
    localparam logic [2:0] RNG_PM5V   = 3'h2;
    localparam logic [2:0] RNG_PM10V  = 3'h3;
    localparam logic [2:0] RNG_4_20MA = 3'h4;
    localparam logic [2:0] RNG_0_20MA = 3'h5;
    localparam logic [2:0] RNG_0_24MA = 3'h6;

    localparam logic [15:0] CLEAR_CODE_RST = 16'h0000;
    localparam logic [15:0] CODE_RST       = 16'h0000;

endpackage

// ===== qdac_serial_host.sv
`timescale 1ns/1ps
// Host end of the serial link; the serial clock idles high and stands still between frames.
module qdac_serial_host (
    output logic sclk,
    output logic syncN,
    output logic sdin
);
    initial begin
        sclk  = 1'b1;
        syncN = 1'b1;
        sdin  = 1'b0;
    end

    // Sends the n low bits of w, top bit first: 24 bits, or 32 with packet checking.
    task automatic send(input logic [31:0] w, input int n);
        syncN = 1'b0;
        #32;
        for (int i = n - 1; i >= 0; i--) begin
            sdin = w[i];
            #32 sclk = 1'b0;
            #32 sclk = 1'b1;
        end
        #32 syncN = 1'b1;
        // The released data line flips so that a stale bit cannot pass for a good one.
        sdin = ~sdin;
        #64;
    endtask
endmodule
